// File: core/charger_input_limit_profile_ctl.sv
`timescale 1ns/1ps
`include "charger_ctl_regs.svh"
module charger_input_limit_profile_ctl #(
  parameter int unsigned WAIT_CYCLES = `WAIT_CYCLES
) (
  input  wire logic                         sys_clk,
  input  wire logic                         srst,
  input  wire logic                         reset_pin_low,
  input  wire logic                         otp_valid,
  input  wire logic [15:0]                  otp_data,
  output logic                              otp_req,
  output logic [4:0]                        otp_index,
  input  wire logic                         bus_present,
  input  wire logic                         adp_present,
  input  wire logic                         external_limit_enable,
  input  wire logic                         bus_det_enable,
  input  wire logic                         adp_det_enable,
  input  wire logic                         bus_det_done,
  input  wire logic                         adp_det_done,
  input  wire logic [15:0]                  bus_det_limit,
  input  wire logic [15:0]                  adp_det_limit,
  input  wire logic [15:0]                  pin_limit,
  input  wire logic                         charge_start,
  input  wire charger_ctl_pkg::temp_zone_t  temp_zone,
  input  wire charger_ctl_pkg::meas_t       meas,
  input  wire charger_ctl_pkg::reg_req_t    req,
  output logic [15:0]                       rdata,
  output logic                              rvalid,
  output logic                              input_good,
  output logic                              limit_enable,
  output logic [15:0]                       active_limit,
  output logic                              converter_enable,
  output logic                              system_rail_enable,
  output logic [15:0]                       charge_current,
  output logic [15:0]                       charge_voltage,
  output charger_ctl_pkg::chg_state_t       chg_state,
  output logic                              battery_short_flag,
  output logic                              vbat_irq_cmp
);
  ////////////////////////////////////////////////////////////////////////
  logic [15:0] regs_reg [0:`OTP_WORDS-1];
  logic        loaded_reg;
  logic [4:0]  load_idx_reg;
  logic [4:0]  widx;
  logic        wvalid;
  logic        hw_rst;
  logic [15:0] status_reg;
  logic        src_present;
  logic        src_present_d_reg;
  logic        det_done_reg;
  logic        host_lim_reg;
  logic [31:0] wait_cnt_reg;
  charger_ctl_pkg::lim_src_t src_reg;
  charger_ctl_pkg::chg_state_t state_reg;
  logic        rail_on_reg;
  logic [15:0] vfull;

  // The reset pin acts as a full device reset, same as srst.
  assign hw_rst      = srst | reset_pin_low; // see R9, see R10
  assign src_present = bus_present | adp_present;

  // Map offsets to array slots; slot order is the OTP load order.
  always_comb begin
    widx   = 5'd0;
    wvalid = 1'b1;
    case (req.addr)
      `OFS_BUS_LIM:  widx = 5'd0;
      `OFS_ADP_LIM:  widx = 5'd1;
      `OFS_MINSYS:   widx = 5'd2;
      `OFS_VALH:     widx = 5'd3;
      `OFS_VALL:     widx = 5'd4;
      `OFS_ITRICKLE: widx = 5'd5;
      `OFS_IPRE:     widx = 5'd6;
      `OFS_IFAST:    widx = 5'd7;
      `OFS_ITERM:    widx = 5'd8;
      `OFS_VTRICKLE: widx = 5'd9;
      `OFS_VFULL_A:  widx = 5'd10;
      `OFS_VFULL_B:  widx = 5'd11;
      `OFS_VFULL_C:  widx = 5'd12;
      `OFS_VRECHG:   widx = 5'd13;
      `OFS_VOVP:     widx = 5'd14;
      `OFS_ISHORT:   widx = 5'd15;
      `OFS_VBAT_IRQ: widx = 5'd16;
      default:       wvalid = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // OTP default load; only the read port and the status clear run until it finishes.
  always_ff @(posedge sys_clk) begin
    if (hw_rst) begin
      loaded_reg   <= 1'b0; // see R1
      load_idx_reg <= 5'd0;
    end else if (!loaded_reg && otp_valid) begin
      if (load_idx_reg == 5'(`OTP_WORDS - 1)) begin
        loaded_reg <= 1'b1;
      end
      load_idx_reg <= load_idx_reg + 5'd1;
    end
  end
  assign otp_req   = !loaded_reg;
  assign otp_index = load_idx_reg;

  // Register array: OTP fills it, then the host may write it.
  always_ff @(posedge sys_clk) begin
    if (!loaded_reg && otp_valid && !hw_rst) begin
      regs_reg[load_idx_reg] <= otp_data; // see R1, see R10
    end else if (loaded_reg && req.wr && wvalid) begin
      if (widx <= 5'd1) begin
        // Out-of-range limit codes are clamped into the legal span.
        if (req.wdata < `LIM_MIN_CODE) begin
          regs_reg[widx] <= `LIM_MIN_CODE; // see R11
        end else if (req.wdata > `LIM_MAX_CODE) begin
          regs_reg[widx] <= `LIM_MAX_CODE; // see R11
        end else begin
          regs_reg[widx] <= req.wdata; // see R6
        end
      end else if (widx == 5'd16 && req.wdata > `VBAT_IRQ_MAX) begin
        regs_reg[widx] <= `VBAT_IRQ_MAX; // see R22
      end else begin
        regs_reg[widx] <= req.wdata;
      end
    end
  end

  // Status: short flag sticks; a host write of one clears it, set wins.
  always_ff @(posedge sys_clk) begin
    if (hw_rst) begin
      status_reg <= 16'h0000;
    end else if (loaded_reg && meas.battery_current_ma > regs_reg[15] && meas.short_wdt_done) begin
      status_reg[`SHORT_BIT] <= 1'b1; // see R21
    end else if (req.wr && req.addr == `OFS_STATUS && req.wdata[`SHORT_BIT]) begin
      status_reg[`SHORT_BIT] <= 1'b0;
    end
  end
  assign battery_short_flag = status_reg[`SHORT_BIT];
  assign vbat_irq_cmp = loaded_reg && (meas.vbat_mv >= regs_reg[16]); // see R22

  always_ff @(posedge sys_clk) begin
    if (hw_rst) begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.addr == `OFS_STATUS) begin
        rdata <= status_reg;
      end else if (wvalid && loaded_reg) begin
        rdata <= regs_reg[widx];
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source insertion, port detection or fixed wait, limit selection.
  always_ff @(posedge sys_clk) begin
    if (hw_rst || !loaded_reg) begin
      src_present_d_reg <= 1'b0;
      input_good        <= 1'b0;
      det_done_reg      <= 1'b0;
      wait_cnt_reg      <= 32'd0;
      src_reg           <= charger_ctl_pkg::SRC_MIN;
      host_lim_reg      <= 1'b0;
    end else begin
      src_present_d_reg <= src_present;
      input_good        <= src_present; // see R2, see R7
      if (!src_present) begin
        det_done_reg <= 1'b0; // see R7
        wait_cnt_reg <= 32'd0;
        host_lim_reg <= 1'b0; // see R25
        src_reg      <= external_limit_enable ? charger_ctl_pkg::SRC_PIN
                                              : charger_ctl_pkg::SRC_MIN; // see R7
      end else if (!src_present_d_reg) begin
        src_reg <= external_limit_enable ? charger_ctl_pkg::SRC_PIN
                                         : charger_ctl_pkg::SRC_MIN; // see R4
      end else if (!det_done_reg) begin
        if ((bus_present ? bus_det_enable : adp_det_enable)) begin
          if (bus_present ? bus_det_done : adp_det_done) begin
            det_done_reg <= 1'b1;
            src_reg      <= charger_ctl_pkg::SRC_DET; // see R5
          end
        end else if (wait_cnt_reg >= 32'(WAIT_CYCLES - 1)) begin
          det_done_reg <= 1'b1; // see R3
        end else begin
          wait_cnt_reg <= wait_cnt_reg + 32'd1; // see R3
        end
      end
      if (src_present && req.wr && (req.addr == `OFS_BUS_LIM || req.addr == `OFS_ADP_LIM)) begin
        host_lim_reg <= 1'b1; // see R6, see R25
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (hw_rst || !loaded_reg) begin
      active_limit <= `LIM_128MA;
    end else if (host_lim_reg) begin
      active_limit <= bus_present ? regs_reg[0] : regs_reg[1]; // see R6
    end else begin
      case (src_reg)
        charger_ctl_pkg::SRC_PIN: active_limit <= pin_limit; // see R4
        charger_ctl_pkg::SRC_DET: active_limit <= bus_present ? bus_det_limit
                                                              : adp_det_limit; // see R5
        default:                  active_limit <= `LIM_128MA; // see R4
      endcase
    end
  end
  assign limit_enable = loaded_reg && !hw_rst && !meas.dead_batt; // see R8

  ////////////////////////////////////////////////////////////////////////
  // Charge profile.
  always_comb begin
    case (temp_zone)
      charger_ctl_pkg::TEMP_T3_T5: vfull = regs_reg[11]; // see R18
      charger_ctl_pkg::TEMP_T5_T4,
      charger_ctl_pkg::TEMP_T1_T2: vfull = regs_reg[12]; // see R18
      default:                     vfull = regs_reg[10]; // see R18
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (hw_rst || !loaded_reg) begin
      state_reg <= charger_ctl_pkg::CHG_IDLE;
    end else if (!input_good || !src_present || !det_done_reg) begin
      // Follow the raw presence level so the profile stops in the cycle that detection
      // is cleared, rather than one cycle later under a stale limit.
      state_reg <= charger_ctl_pkg::CHG_IDLE; // see R2
    end else begin
      case (state_reg)
        charger_ctl_pkg::CHG_IDLE:
          if (charge_start) begin
            state_reg <= charger_ctl_pkg::CHG_TRICKLE;
          end
        charger_ctl_pkg::CHG_TRICKLE:
          if (meas.vbat_mv >= regs_reg[9]) begin
            state_reg <= charger_ctl_pkg::CHG_PRE; // see R16
          end
        charger_ctl_pkg::CHG_PRE:
          if (meas.vbat_mv >= regs_reg[2]) begin
            state_reg <= charger_ctl_pkg::CHG_FAST; // see R17
          end
        charger_ctl_pkg::CHG_FAST:
          if (meas.vbat_mv >= vfull && meas.battery_current_ma < regs_reg[8]) begin
            state_reg <= charger_ctl_pkg::CHG_FULL; // see R13
          end
        charger_ctl_pkg::CHG_FULL:
          if (meas.vbat_mv <= regs_reg[13]) begin
            state_reg <= charger_ctl_pkg::CHG_FAST; // see R20
          end
        default: state_reg <= charger_ctl_pkg::CHG_IDLE;
      endcase
    end
  end
  assign chg_state = state_reg;

  always_ff @(posedge sys_clk) begin
    if (hw_rst || !loaded_reg) begin
      charge_current <= 16'h0000;
      charge_voltage <= 16'h0000;
    end else begin
      case (state_reg)
        charger_ctl_pkg::CHG_TRICKLE: charge_current <= regs_reg[5];
        charger_ctl_pkg::CHG_PRE:     charge_current <= regs_reg[6];
        charger_ctl_pkg::CHG_FAST:    charge_current <= regs_reg[7];
        default:                      charge_current <= 16'h0000;
      endcase
      charge_voltage <= vfull;
    end
  end

  // Rail hysteresis is frozen while a charge is in progress.
  always_ff @(posedge sys_clk) begin
    if (hw_rst || !loaded_reg || !input_good) begin
      rail_on_reg <= 1'b0; // see R9
    end else if (state_reg == charger_ctl_pkg::CHG_IDLE ||
                 state_reg == charger_ctl_pkg::CHG_FULL) begin
      if (meas.system_rail_mv > regs_reg[3]) begin
        rail_on_reg <= 1'b1; // see R14
      end else if (meas.system_rail_mv < regs_reg[4]) begin
        rail_on_reg <= 1'b0; // see R14
      end
    end
  end
  assign system_rail_enable = rail_on_reg; // see R15
  assign converter_enable   = rail_on_reg && det_done_reg; // see R2

  ////////////////////////////////////////////////////////////////////////
  property p_reset_pin_stops;
    @(posedge sys_clk) reset_pin_low |=> !converter_enable && !input_good;
  endproperty
  a_reset_pin_stops: assert property (p_reset_pin_stops) else $error("reset pin"); // see R9

  property p_dead_batt;
    @(posedge sys_clk) disable iff (srst) meas.dead_batt |-> !limit_enable;
  endproperty
  a_dead_batt: assert property (p_dead_batt) else $error("dead battery limit"); // see R8

  property p_no_charge_before_load;
    @(posedge sys_clk) disable iff (srst)
      !loaded_reg |-> chg_state == charger_ctl_pkg::CHG_IDLE && !converter_enable;
  endproperty
  a_no_charge_before_load: assert property (p_no_charge_before_load)
    else $error("activity before load"); // see R1

  sequence s_source_gone;
    loaded_reg && !src_present;
  endsequence

  property p_removal;
    @(posedge sys_clk) disable iff (hw_rst)
      s_source_gone ##1 s_source_gone |=> !input_good;
  endproperty
  a_removal: assert property (p_removal) else $error("input good on removal"); // see R7

  property p_short_flag;
    @(posedge sys_clk) disable iff (hw_rst)
      loaded_reg && meas.battery_current_ma > regs_reg[15] && meas.short_wdt_done
      |=> battery_short_flag;
  endproperty
  a_short_flag: assert property (p_short_flag) else $error("short flag"); // see R21

  property p_trickle_pre;
    @(posedge sys_clk) disable iff (hw_rst)
      chg_state == charger_ctl_pkg::CHG_TRICKLE && input_good && src_present && det_done_reg &&
      meas.vbat_mv >= regs_reg[9] |=> chg_state == charger_ctl_pkg::CHG_PRE;
  endproperty
  a_trickle_pre: assert property (p_trickle_pre) else $error("trickle step"); // see R16

  property p_pre_fast;
    @(posedge sys_clk) disable iff (hw_rst)
      chg_state == charger_ctl_pkg::CHG_PRE && input_good && src_present && det_done_reg &&
      meas.vbat_mv >= regs_reg[2] |=> chg_state == charger_ctl_pkg::CHG_FAST;
  endproperty
  a_pre_fast: assert property (p_pre_fast) else $error("precharge step"); // see R17

  sequence s_fast_on;
    input_good && chg_state == charger_ctl_pkg::CHG_FAST;
  endsequence

  property p_rail_frozen;
    @(posedge sys_clk) disable iff (hw_rst)
      s_fast_on ##1 s_fast_on |-> $stable(system_rail_enable);
  endproperty
  a_rail_frozen: assert property (p_rail_frozen) else $error("rail changed"); // see R15

  property p_no_limit_before_det;
    @(posedge sys_clk) disable iff (hw_rst)
      !det_done_reg |-> chg_state == charger_ctl_pkg::CHG_IDLE;
  endproperty
  a_no_limit_before_det: assert property (p_no_limit_before_det)
    else $error("charge before detection"); // see R2

  property p_reset_defaults;
    @(posedge sys_clk) hw_rst |=> !loaded_reg && active_limit == `LIM_128MA;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("registers not back to defaults"); // see R10

  sequence s_term_reached;
    chg_state == charger_ctl_pkg::CHG_FAST && input_good && src_present &&
    det_done_reg && meas.vbat_mv >= vfull && meas.battery_current_ma < regs_reg[8];
  endsequence

  property p_terminate;
    @(posedge sys_clk) disable iff (hw_rst)
      s_term_reached |=> chg_state == charger_ctl_pkg::CHG_FULL;
  endproperty
  a_terminate: assert property (p_terminate) else $error("termination step"); // see R13

  property p_recharge;
    @(posedge sys_clk) disable iff (hw_rst)
      chg_state == charger_ctl_pkg::CHG_FULL && input_good && src_present && det_done_reg &&
      meas.vbat_mv <= regs_reg[13] |=> chg_state == charger_ctl_pkg::CHG_FAST;
  endproperty
  a_recharge: assert property (p_recharge) else $error("recharge step"); // see R20
endmodule : charger_input_limit_profile_ctl

// File: core/charger_ctl_regs.svh
`ifndef CHARGER_CTL_REGS_SVH
`define CHARGER_CTL_REGS_SVH
// Contract
// R1 - On battery power-up, load register defaults from OTP before any activity.
// R2 - On source plug-in assert input good, detect port, then limit and charge.
// R3 - Each port either detects or waits 100ms before detection counts finished.
// R4 - Startup limit is pin divider when external limit enable is 1, else 128mA.
// R5 - With detection enabled, detection result replaces the startup limit.
// R6 - Host writes per-port limit registers; written value becomes active limit.
// R7 - On source removal drop input good and return limit to divider or minimum.
// R8 - While dead-battery comparator flags bad battery, input limiting is disabled.
// R9 - Reset pin below 0.44V stops every function regardless of state.
// R10 - Reset through the reset pin returns every register to its default.
// R11 - Limit registers span 96 to 16352 mA at 32 mA per code.
// R12 - Host should program termination current at 300mA or more.
// R13 - While charging, end charge when battery current falls below termination.
// R14 - Outside charging, rail on above high threshold, off below low threshold.
// R15 - While charging, rail operation ignores threshold rewrites or crossings.
// R16 - Trickle moves to pre-charge when battery reaches trickle threshold.
// R17 - Pre-charge moves to fast charge at the minimum system voltage.
// R18 - Full-charge register b in T3-T5, c in T5-T4 and T1-T2, else a.
// R19 - Host should program all three full-charge registers alike if unwanted.
// R20 - After full charge, restart when battery falls to recharge threshold.
// R21 - Short current past watchdog sets status bit 6; charging continues.
// R22 - Battery irq threshold holds 0 to 19200mV, 1mV, compared for irq select.
// R23 - Host should set overvoltage about 10 percent above full-charge a.
// R24 - Host should set trickle and pre-charge near one tenth of fast current.
// R25 - A host-written limit stays in force until removal or reset.

`define OFS_BUS_LIM    8'h07
`define OFS_ADP_LIM    8'h08
`define OFS_STATUS     8'h01
`define OFS_MINSYS     8'h11
`define OFS_VALH       8'h12
`define OFS_VALL       8'h13
`define OFS_ITRICKLE   8'h14
`define OFS_IPRE       8'h15
`define OFS_IFAST      8'h16
`define OFS_ITERM      8'h17
`define OFS_VTRICKLE   8'h18
`define OFS_VFULL_A    8'h1a
`define OFS_VFULL_B    8'h1b
`define OFS_VFULL_C    8'h1c
`define OFS_VRECHG     8'h1d
`define OFS_VOVP       8'h1e
`define OFS_ISHORT     8'h1f
`define OFS_VBAT_IRQ   8'h48
`define SHORT_BIT      6
`define LIM_MIN_CODE   16'h0003
`define LIM_MAX_CODE   16'h01ff
`define LIM_128MA      16'h0004
`define VBAT_IRQ_MAX   16'h4b00
`define WAIT_MS        100
`define CLK_KHZ        50000
`define WAIT_CYCLES    (`WAIT_MS * `CLK_KHZ)
`define OTP_WORDS      17
`endif

// File: core/charger_ctl_pkg.sv
package charger_ctl_pkg;
  typedef enum logic [2:0] {
    CHG_IDLE, CHG_TRICKLE, CHG_PRE, CHG_FAST, CHG_FULL
  } chg_state_t;
  typedef enum logic [1:0] {
    SRC_MIN, SRC_PIN, SRC_DET, SRC_HOST
  } lim_src_t;
  typedef enum logic [1:0] {
    TEMP_NORMAL, TEMP_T3_T5, TEMP_T5_T4, TEMP_T1_T2
  } temp_zone_t;
  typedef struct packed {
    logic [15:0] vbat_mv;
    logic [15:0] battery_current_ma;
    logic [15:0] system_rail_mv;
    logic        dead_batt;
    logic        short_wdt_done;
  } meas_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;
endpackage : charger_ctl_pkg

// File: testbench/host_mcu_model.sv
`timescale 1ns/1ps
module host_mcu_model (
  input  wire logic                  sys_clk,
  input  wire logic [15:0]           rdata,
  input  wire logic                  rvalid,
  output charger_ctl_pkg::reg_req_t  req
);
  initial req = '0;

  ////////////////////////////////////////
  // Strobes last exactly one cycle, so the host never repeats a write by accident.
  // Callers keep limit codes inside the legal span unless a clamp is under test.
  task automatic reg_write(input logic [7:0] addr, input logic [15:0] data);
    @(posedge sys_clk);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge sys_clk);
    #1 req = '0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] addr, output logic [15:0] data, output logic ok);
    @(posedge sys_clk);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
    @(posedge sys_clk);
    #1 req = '0;
    ok = rvalid;
    data = rdata;
  endtask : reg_read
endmodule : host_mcu_model

// File: testbench/charger_input_limit_profile_ctl_tb.sv
`timescale 1ns/1ps
module charger_input_limit_profile_ctl_tb;
  localparam int unsigned WAIT_N = 20;
  localparam logic [7:0]  OFS [17] = '{8'h07, 8'h08, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
    8'h16, 8'h17, 8'h18, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h48};
  // Defaults for a two-cell pack, kept in the order the loader asks for them.
  localparam logic [15:0] DEF [17] = '{16'h0010, 16'h0010, 16'h1800, 16'h1600, 16'h1400,
    16'h0100, 16'h00c0, 16'h0a00, 16'h0140, 16'h1000, 16'h20d0, 16'h2000, 16'h1f00,
    16'h1e00, 16'h2418, 16'h0c00, 16'h1c00};
  logic                           sys_clk = 1'b0;
  logic                           srst = 1'b1;
  logic                           reset_pin_low = 1'b0;
  logic                           otp_valid = 1'b0;
  logic [15:0]                    otp_data;
  logic                           bus_present = 1'b0;
  logic                           adp_present = 1'b0;
  logic                           external_limit_enable = 1'b0;
  logic                           bus_det_enable = 1'b0;
  logic                           adp_det_enable = 1'b0;
  logic                           bus_det_done = 1'b0;
  logic                           adp_det_done = 1'b0;
  logic [15:0]                    bus_det_limit = 16'h002f;
  logic [15:0]                    adp_det_limit = 16'h0030;
  logic [15:0]                    pin_limit = 16'h0020;
  logic                           charge_start = 1'b0;
  charger_ctl_pkg::temp_zone_t    temp_zone = charger_ctl_pkg::TEMP_NORMAL;
  charger_ctl_pkg::meas_t         meas = '{16'h0e00, 16'h0100, 16'h1700, 1'b0, 1'b0};
  charger_ctl_pkg::reg_req_t      req;
  charger_ctl_pkg::chg_state_t    chg_state;
  logic [15:0]                    rdata, active_limit, charge_current, charge_voltage;
  logic [4:0]                     otp_index;
  logic                           otp_req, rvalid, input_good, limit_enable;
  logic                           converter_enable, system_rail_enable;
  logic                           battery_short_flag, vbat_irq_cmp;
  int                             n_mismatch = 0;
  int                             n_checks = 0;

  assign otp_data = (otp_index < 5'd17) ? DEF[otp_index] : 16'h0000;
  always #10 sys_clk = ~sys_clk;

  charger_input_limit_profile_ctl #(.WAIT_CYCLES(WAIT_N)) i_charger_input_limit_profile_ctl (.*);
  host_mcu_model i_host_mcu_model (.*);

  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_up(input string what);
    check(what, 16'h0000, 16'h0001);
    conclude();
  endtask : give_up

  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    logic        ok;
    i_host_mcu_model.reg_read(a, d, ok);
    check(what, (ok === 1'b1) ? d : 16'hxxxx, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_host_mcu_model.reg_write(a, d);
  endtask : wr

  task automatic wait_state(input charger_ctl_pkg::chg_state_t s, input string what);
    for (int i = 0; i < 40; i++) begin
      if (chg_state === s) begin
        check(what, 16'(chg_state), 16'(s));
        tick(1);
        return;
      end
      tick(1);
    end
    give_up(what);
  endtask : wait_state

  task automatic otp_load();
    otp_valid = 1'b1;
    for (int i = 0; i < 60 && otp_req !== 1'b0; i++) begin
      tick(1);
    end
    otp_valid = 1'b0;
    if (otp_req !== 1'b0) begin
      give_up("otp load");
    end
  endtask : otp_load

  ////////////////////////////////////////
  task automatic t_load();
    wr(8'h16, 16'h0123);
    check("converter before load", 16'(converter_enable), 16'h0000);
    otp_load();
    foreach (OFS[i]) rd(OFS[i], DEF[i], "default");
    rd(8'h02, 16'h0000, "unmapped");
    $display("test load done");
  endtask : t_load

  task automatic t_ports();
    external_limit_enable = 1'b1;
    bus_det_enable = 1'b1;
    bus_present = 1'b1;
    tick(2);
    check("input good", 16'(input_good), 16'h0001);
    tick(1);
    check("startup limit", active_limit, pin_limit);
    tick(6);
    check("limit before detect", active_limit, pin_limit);
    bus_det_done = 1'b1;
    tick(3);
    check("detect limit", active_limit, bus_det_limit);
    wr(8'h07, 16'h0040);
    tick(3);
    check("host limit", active_limit, 16'h0040);
    tick(12);
    check("host limit kept", active_limit, 16'h0040);
    meas.dead_batt = 1'b1;
    tick(2);
    check("limit off", 16'(limit_enable), 16'h0000);
    meas.dead_batt = 1'b0;
    tick(2);
    check("limit on", 16'(limit_enable), 16'h0001);
    bus_present = 1'b0;
    bus_det_done = 1'b0;
    tick(3);
    check("input good off", 16'(input_good), 16'h0000);
    check("limit after removal", active_limit, pin_limit);
    external_limit_enable = 1'b0;
    adp_present = 1'b1;
    tick(3);
    check("minimum limit", active_limit, 16'h0004);
    check("converter waits", 16'(converter_enable), 16'h0000);
    tick(WAIT_N + 4);
    check("converter after wait", 16'(converter_enable), 16'h0001);
    check("limit without detect", active_limit, 16'h0004);
    wr(8'h08, 16'h0001);
    rd(8'h08, 16'h0003, "limit floor");
    wr(8'h08, 16'hffff);
    rd(8'h08, 16'h01ff, "limit ceiling");
    check("adapter host limit", active_limit, 16'h01ff);
    adp_present = 1'b0;
    tick(3);
    check("override cleared", active_limit, 16'h0004);
    $display("test ports done");
  endtask : t_ports

  task automatic t_charge();
    adp_present = 1'b1;
    tick(WAIT_N + 4);
    charge_start = 1'b1;
    tick(1);
    charge_start = 1'b0;
    wait_state(charger_ctl_pkg::CHG_TRICKLE, "trickle");
    check("trickle current", charge_current, DEF[5]);
    meas.vbat_mv = DEF[9];
    wait_state(charger_ctl_pkg::CHG_PRE, "pre");
    check("pre current", charge_current, DEF[6]);
    meas.vbat_mv = DEF[2];
    wait_state(charger_ctl_pkg::CHG_FAST, "fast");
    check("fast current", charge_current, DEF[7]);
    meas.system_rail_mv = 16'h1300;
    wr(8'h12, 16'h1e00);
    tick(3);
    check("rail held", 16'(system_rail_enable), 16'h0001);
    wr(8'h12, DEF[3]);
    meas.system_rail_mv = 16'h1700;
    for (int z = 0; z < 4; z++) begin
      temp_zone = charger_ctl_pkg::temp_zone_t'(z);
      tick(3);
      check("full voltage", charge_voltage, z == 0 ? DEF[10] : z == 1 ? DEF[11] : DEF[12]);
    end
    temp_zone = charger_ctl_pkg::TEMP_NORMAL;
    meas.vbat_mv = DEF[10];
    wait_state(charger_ctl_pkg::CHG_FULL, "full");
    meas.vbat_mv = DEF[13];
    wait_state(charger_ctl_pkg::CHG_FAST, "recharge");
    meas.battery_current_ma = 16'h0d00;
    meas.short_wdt_done = 1'b1;
    tick(3);
    check("short flag", 16'(battery_short_flag), 16'h0001);
    rd(8'h01, 16'h0040, "status");
    check("still charging", 16'(chg_state), 16'(charger_ctl_pkg::CHG_FAST));
    meas.battery_current_ma = 16'h0100;
    meas.short_wdt_done = 1'b0;
    wr(8'h01, 16'h0040);
    tick(2);
    check("short cleared", 16'(battery_short_flag), 16'h0000);
    wr(8'h48, 16'hffff);
    rd(8'h48, 16'h4b00, "irq ceiling");
    wr(8'h48, 16'h1e00);
    tick(1);
    check("irq at threshold", 16'(vbat_irq_cmp), 16'h0001);
    meas.vbat_mv = 16'h1dff;
    tick(1);
    check("irq below", 16'(vbat_irq_cmp), 16'h0000);
    adp_present = 1'b0;
    tick(1);
    check("removal stops charge", 16'(chg_state), 16'(charger_ctl_pkg::CHG_IDLE));
    adp_present = 1'b1;
    $display("test charge done");
  endtask : t_charge

  task automatic t_reset_rail();
    reset_pin_low = 1'b1;
    tick(2);
    check("stopped", 16'(chg_state), 16'(charger_ctl_pkg::CHG_IDLE));
    check("converter off", 16'(converter_enable), 16'h0000);
    check("rail off", 16'(system_rail_enable), 16'h0000);
    check("limit reset", active_limit, 16'h0004);
    reset_pin_low = 1'b0;
    tick(1);
    otp_load();
    rd(8'h48, DEF[16], "irq default");
    rd(8'h08, DEF[1], "limit default");
    tick(3);
    check("rail up", 16'(system_rail_enable), 16'h0001);
    meas.system_rail_mv = 16'h1300;
    tick(3);
    check("rail down", 16'(system_rail_enable), 16'h0000);
    meas.system_rail_mv = 16'h1500;
    tick(3);
    check("rail hysteresis", 16'(system_rail_enable), 16'h0000);
    $display("test reset and rail done");
  endtask : t_reset_rail

  initial begin
    tick(2);
    srst = 1'b0;
    t_load();
    t_ports();
    t_charge();
    t_reset_rail();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    give_up("timeout");
  end
endmodule : charger_input_limit_profile_ctl_tb
